// ---- stepper_pkg.sv ----
// Shared constants and types for the stepper phase sequencer
package stepper_pkg;
   localparam logic [2:0] STATE_ONE = 3'h0;
   localparam logic [2:0] STATE_EIGHT = 3'h7;
   localparam logic [2:0] STEP_HALF = 3'h1;
   localparam logic [2:0] STEP_FULL = 3'h2;
   localparam int SYNC_DEPTH = 3;
   // Bridge decode word: {phase_a, en_a, phase_b, en_b}
   localparam logic [3:0] DRIVE_S1 = 4'hF;
   localparam logic [3:0] DRIVE_S2 = 4'hC;
   localparam logic [3:0] DRIVE_S3 = 4'h7;
   localparam logic [3:0] DRIVE_S4 = 4'h3;
   localparam logic [3:0] DRIVE_S5 = 4'h5;
   localparam logic [3:0] DRIVE_S6 = 4'h4;
   localparam logic [3:0] DRIVE_S7 = 4'hD;
   localparam logic [3:0] DRIVE_S8 = 4'h1;
   typedef enum logic [1:0] {
      GATE_RUN = 2'b00,
      GATE_OVERCURRENT = 2'b01,
      GATE_RECOVER = 2'b10
   } gate_state_t;
endpackage : stepper_pkg

// ---- pin_sync_if.sv ----
// Synchronised pin levels and change events between sequencer modules
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if;
   logic step_rise;
   logic half_sel;
   logic direction_select;
   logic en_level;
   logic thermal_hot;
   logic overcurrent_detector;
   modport source (output step_rise, half_sel, direction_select, en_level, thermal_hot,
      overcurrent_detector);
   modport sink (input step_rise, half_sel, direction_select, en_level, thermal_hot,
      overcurrent_detector);
endinterface : pin_sync_if
`default_nettype wire

// ---- pin_sync.sv ----
// Three-stage synchronisers with agreement filter for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic step_clock_pin,
   input wire logic half_sel_pin,
   input wire logic direction_pin,
   input wire logic en_pin_in,
   input wire logic thermal_pin,
   input wire logic overcurrent_pin,
   pin_sync_if.source sync
);
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] level;
      logic rise;
   } sync_state_t;
   sync_state_t state_r;
   sync_state_t state_nxt;
   always_comb begin
      state_nxt = state_r;
      state_nxt.rise = 1'b0;
      state_nxt.s1 = {overcurrent_pin, thermal_pin, en_pin_in, direction_pin,
         half_sel_pin, step_clock_pin};
      state_nxt.s2 = state_r.s1;
      state_nxt.s3 = state_r.s2;
      for (int i = 0; i < 6; i++) begin
         if (state_r.s2[i] == state_r.s3[i]) begin
            state_nxt.level[i] = state_r.s2[i];
         end
      end
      // Step edge counted once on filtered rising level change
      if (state_nxt.level[0] && !state_r.level[0]) begin
         state_nxt.rise = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= '0;
         state_r.level[3] <= 1'b1;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end
   assign sync.step_rise = state_r.rise;
   assign sync.half_sel = state_r.level[1];
   assign sync.direction_select = state_r.level[2];
   assign sync.en_level = state_r.level[3];
   assign sync.thermal_hot = state_r.level[4];
   assign sync.overcurrent_detector = state_r.level[5];
endmodule : pin_sync
`default_nettype wire

// ---- stepper_phase_sequencer.sv ----
// Phase sequence generator with fault-driven bridge disable
`timescale 1ns/10ps
`default_nettype none
module stepper_phase_sequencer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic step_clock,
   input wire logic half_sel,
   input wire logic direction_select,
   input wire logic seq_reset,
   input wire logic en_pin_in,
   input wire logic thermal_hot_in,
   input wire logic overcurrent_detector,
   output logic en_pin_out,
   output logic en_pin_oe,
   output logic phase_a,
   output logic enable_a,
   output logic phase_b,
   output logic enable_b,
   output logic [2:0] seq_state,
   output logic fault_active
);
   pin_sync_if sync ();

   pin_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .clk_en(clk_en),
      .step_clock_pin(step_clock),
      .half_sel_pin(half_sel),
      .direction_pin(direction_select),
      .en_pin_in(en_pin_in),
      .thermal_pin(thermal_hot_in),
      .overcurrent_pin(overcurrent_detector),
      .sync(sync)
   );

   typedef struct packed {
      logic [2:0] state;
      stepper_pkg::gate_state_t gate;
      logic pull_low;
      logic [3:0] drive;
      logic fault;
      logic reset_s1;
      logic reset_s2;
      logic reset_s3;
      logic reset_lvl;
   } seq_state_t;

   seq_state_t state_r;
   seq_state_t state_nxt;

   // Next sequencer state for one step
   function automatic logic [2:0] next_state(input logic [2:0] cur, input logic half,
      input logic dir);
      logic [2:0] inc;
      inc = half ? stepper_pkg::STEP_HALF : stepper_pkg::STEP_FULL;
      // Odd/even parity is kept by the stride of two
      if (dir) begin
         next_state = 3'(cur + inc);
      end else begin
         next_state = 3'(cur - inc);
      end
   endfunction : next_state

   // Bridge drive pattern for a state
   function automatic logic [3:0] decode(input logic [2:0] s);
      case (s)
         3'h0: decode = stepper_pkg::DRIVE_S1;
         3'h1: decode = stepper_pkg::DRIVE_S2;
         3'h2: decode = stepper_pkg::DRIVE_S3;
         3'h3: decode = stepper_pkg::DRIVE_S4;
         3'h4: decode = stepper_pkg::DRIVE_S5;
         3'h5: decode = stepper_pkg::DRIVE_S6;
         3'h6: decode = stepper_pkg::DRIVE_S7;
         3'h7: decode = stepper_pkg::DRIVE_S8;
         default: decode = stepper_pkg::DRIVE_S1;
      endcase
   endfunction : decode

   always_comb begin
      state_nxt = state_r;
      state_nxt.reset_s1 = seq_reset;
      state_nxt.reset_s2 = state_r.reset_s1;
      state_nxt.reset_s3 = state_r.reset_s2;
      if (state_r.reset_s2 == state_r.reset_s3) begin
         state_nxt.reset_lvl = state_r.reset_s2;
      end
      if (state_r.reset_lvl) begin
         // Reset input holds state 1 whatever select and direction say
         state_nxt.state = stepper_pkg::STATE_ONE;
      end else if (sync.step_rise) begin
         // Stride follows half select, direction follows direction select
         state_nxt.state = next_state(state_r.state, sync.half_sel, sync.direction_select);
      end
      case (state_r.gate)
         stepper_pkg::GATE_RUN: begin
            state_nxt.pull_low = 1'b0;
            if (sync.overcurrent_detector) begin
               state_nxt.gate = stepper_pkg::GATE_OVERCURRENT;
               state_nxt.pull_low = 1'b1;
            end
         end
         stepper_pkg::GATE_OVERCURRENT: begin
            state_nxt.pull_low = 1'b1;
            if (!sync.overcurrent_detector) begin
               // Release the pin; external RC sets the recovery time
               state_nxt.gate = stepper_pkg::GATE_RECOVER;
               state_nxt.pull_low = 1'b0;
            end
         end
         stepper_pkg::GATE_RECOVER: begin
            state_nxt.pull_low = 1'b0;
            if (sync.overcurrent_detector) begin
               state_nxt.gate = stepper_pkg::GATE_OVERCURRENT;
               state_nxt.pull_low = 1'b1;
            end else if (sync.en_level) begin
               state_nxt.gate = stepper_pkg::GATE_RUN;
            end
         end
         default: begin
            state_nxt.gate = stepper_pkg::GATE_RUN;
            state_nxt.pull_low = 1'b0;
         end
      endcase
      // Bridges off while faulted, pin low or too hot
      state_nxt.fault = (state_nxt.gate != stepper_pkg::GATE_RUN) || sync.thermal_hot;
      state_nxt.drive = decode(state_nxt.state);
      if (state_nxt.fault || !sync.en_level) begin
         state_nxt.drive[2] = 1'b0;
         state_nxt.drive[0] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= '0;
         state_r.gate <= stepper_pkg::GATE_RUN;
         state_r.drive <= 4'hA;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   assign en_pin_out = 1'b0;
   assign en_pin_oe = state_r.pull_low;
   assign phase_a = state_r.drive[3];
   assign enable_a = state_r.drive[2];
   assign phase_b = state_r.drive[1];
   assign enable_b = state_r.drive[0];
   assign seq_state = state_r.state;
   assign fault_active = state_r.fault;
endmodule : stepper_phase_sequencer
`default_nettype wire

// ---- seq_asserts.sv ----
// Port assertions for the stepper phase sequencer
`timescale 1ns/10ps
`default_nettype none
module seq_asserts (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic step_clock,
   input wire logic half_sel,
   input wire logic direction_select,
   input wire logic seq_reset,
   input wire logic en_pin_in,
   input wire logic overcurrent_detector,
   input wire logic en_pin_out,
   input wire logic en_pin_oe,
   input wire logic enable_a,
   input wire logic enable_b,
   input wire logic [2:0] seq_state,
   input wire logic fault_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_rise;
      $changed(seq_state) |-> $past(step_clock) || seq_state == 3'h0;
   endproperty
   a_rise: assert property (p_rise) else $error("state moved off edge");
   property p_hu;
      $changed(seq_state) && half_sel && direction_select && !seq_reset
         |-> seq_state == $past(seq_state) + 3'h1;
   endproperty
   a_hu: assert property (p_hu) else $error("half up");
   property p_hd;
      $changed(seq_state) && half_sel && !direction_select && !seq_reset
         |-> seq_state == $past(seq_state) - 3'h1;
   endproperty
   a_hd: assert property (p_hd) else $error("half down");
   property p_fu;
      $changed(seq_state) && !half_sel && direction_select && !seq_reset
         |-> seq_state == $past(seq_state) + 3'h2;
   endproperty
   a_fu: assert property (p_fu) else $error("full up");
   property p_fd;
      $changed(seq_state) && !half_sel && !direction_select && !seq_reset
         |-> seq_state == $past(seq_state) - 3'h2;
   endproperty
   a_fd: assert property (p_fd) else $error("full down");
   property p_rst;
      seq_reset [*6] |-> seq_state == 3'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_ocd;
      overcurrent_detector [*6] |-> en_pin_oe && !en_pin_out && !enable_a && !enable_b;
   endproperty
   a_ocd: assert property (p_ocd) else $error("overcurrent");
   property p_rec;
      $fell(fault_active) |-> $past(en_pin_in, 3);
   endproperty
   a_rec: assert property (p_rec) else $error("early resume");
endmodule : seq_asserts
bind stepper_phase_sequencer seq_asserts seq_asserts_inst (.clk_sys, .rst, .step_clock,
   .half_sel, .direction_select, .seq_reset, .en_pin_in, .overcurrent_detector, .en_pin_out,
   .en_pin_oe, .enable_a, .enable_b, .seq_state, .fault_active);
`default_nettype wire

// ---- host_ctrl_model.sv ----
// Host controller model with the enable pin RC network
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model #(parameter int RC_CYCLES = 20) (
   input wire logic clk_sys,
   input wire logic en_pin_oe,
   output logic step_clock,
   output logic half_sel,
   output logic direction_select,
   output logic seq_reset,
   output logic en_pin_in
);
   int rc_cnt = RC_CYCLES;
   initial {step_clock, half_sel, direction_select, seq_reset} = 4'h0;
   // Pin recharges only after the open drain lets go
   always @(posedge clk_sys)
      rc_cnt <= en_pin_oe ? 0 : rc_cnt + int'(rc_cnt < RC_CYCLES);
   assign en_pin_in = !en_pin_oe && rc_cnt == RC_CYCLES;
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : idle
   task automatic pulse();
      step_clock = 1'b1;
      idle(5);
      step_clock = 1'b0;
      idle(5);
   endtask : pulse
   task automatic mode(input logic h, input logic d);
      half_sel = h;
      direction_select = d;
      idle(5);
   endtask : mode
   task automatic restart(input logic h, input logic d);
      mode(h, d);
      seq_reset = 1'b1;
      idle(6);
      seq_reset = 1'b0;
      idle(5);
   endtask : restart
endmodule : host_ctrl_model
`default_nettype wire

// ---- tb_stepper_phase_sequencer.sv ----
// Self-checking bench for the stepper phase sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_stepper_phase_sequencer;
   localparam logic [3:0] DEC [8] = '{4'hF, 4'hC, 4'h7, 4'h3, 4'h5, 4'h4, 4'hD, 4'h1};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic thermal_hot_in = 1'b0;
   logic overcurrent_detector = 1'b0;
   logic step_clock, half_sel, direction_select, seq_reset, en_pin_in, en_pin_out, en_pin_oe;
   logic phase_a, enable_a, phase_b, enable_b, fault_active;
   logic [2:0] seq_state;
   int err_count = 0;
   int n_tests = 0;
   stepper_phase_sequencer stepper_phase_sequencer_inst (.clk_sys, .rst, .clk_en, .step_clock,
      .half_sel, .direction_select, .seq_reset, .en_pin_in, .thermal_hot_in,
      .overcurrent_detector, .en_pin_out, .en_pin_oe, .phase_a, .enable_a, .phase_b,
      .enable_b, .seq_state, .fault_active);
   host_ctrl_model host (.clk_sys, .en_pin_oe, .step_clock, .half_sel, .direction_select,
      .seq_reset, .en_pin_in);
   initial forever #25 clk_sys = ~clk_sys;
   task automatic end_sim();
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_count++;
      end_sim();
   end
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic look(input logic [2:0] s);
      check({1'b0, seq_state}, {1'b0, s});
      check({phase_a, enable_a, phase_b, enable_b}, DEC[s]);
   endtask : look
   task automatic walk(input logic h, input logic d, input int n, input int s0, input int k);
      host.mode(h, d);
      for (int i = 1; i <= n; i++) begin
         host.pulse();
         look(3'(s0 + k * i));
      end
   endtask : walk
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      host.idle(6);
      look(3'h0);
      walk(1'b1, 1'b1, 9, 0, 1);
      walk(1'b1, 1'b0, 9, 1, -1);
      host.restart(1'b0, 1'b1);
      look(3'h0);
      walk(1'b0, 1'b1, 5, 0, 2);
      walk(1'b0, 1'b0, 5, 2, -2);
      host.restart(1'b1, 1'b1);
      walk(1'b1, 1'b1, 1, 0, 1);
      walk(1'b0, 1'b1, 4, 1, 2);
      walk(1'b0, 1'b0, 4, 1, -2);
      host.restart(1'b1, 1'b0);
      walk(1'b1, 1'b0, 1, 0, -1);
      walk(1'b0, 1'b0, 2, 7, -2);
      overcurrent_detector = 1'b1;
      host.idle(6);
      check({en_pin_oe, enable_a, enable_b, fault_active}, 4'h9);
      check({3'h0, en_pin_out}, 4'h0);
      overcurrent_detector = 1'b0;
      host.idle(8);
      check({3'h0, fault_active}, 4'h1);
      host.idle(30);
      look(3'h3);
      thermal_hot_in = 1'b1;
      host.idle(6);
      check({1'b0, enable_a, enable_b, fault_active}, 4'h1);
      thermal_hot_in = 1'b0;
      host.idle(6);
      look(3'h3);
      // Frozen clock enable swallows a whole step pulse
      clk_en = 1'b0;
      host.pulse();
      look(3'h3);
      clk_en = 1'b1;
      host.idle(6);
      look(3'h3);
      end_sim();
   end
endmodule : tb_stepper_phase_sequencer
`default_nettype wire
